// [hw/ttc_pkg.sv]
package ttc_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses, one word each)
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] LOW_OFS = 8'h04;
    localparam logic [7:0] HIGH_OFS = 8'h08;
    localparam logic [7:0] IRQ_OFS = 8'h0c;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int IRQ_FLAG_BIT = 0;
    localparam int IRQ_EN_BIT = 1;
    localparam logic [15:0] COUNT_MAX = 16'hffff;
    localparam logic [15:0] COUNT_ZERO = 16'h0000;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

    // ------------------------------------------------------------
    // Timing: instruction cycle is the system clock divided by four
    // ------------------------------------------------------------
    localparam logic [1:0] INSTR_DIV_SEL = 2'h2;

    // Control register layout, bit 7 down to bit 0
    typedef struct packed {
        logic wide_access_mode;
        logic sysclk_from_osc_status;
        logic [1:0] prescale_select;
        logic osc_enable;
        logic ext_sync_disable;
        logic clock_source_select;
        logic count_run;
    } ttc_ctrl_s;

    localparam ttc_ctrl_s CTRL_RESET = '{default: 1'b0};

    // Operating modes, one-hot
    typedef enum logic [2:0] {
        MODE_TIMER = 3'h1,
        MODE_SYNC_CNT = 3'h2,
        MODE_ASYNC_CNT = 3'h4
    } ttc_mode_e;

endpackage : ttc_pkg

// [hw/ttc_prescale.sv]
`timescale 1ns/1ps
`default_nettype none

// Divides a tick stream by 1, 2, 4 or 8; cleared counts restart the ratio
module ttc_prescale #(
    parameter int CNT_W = 3
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Control
    input wire logic clr,
    input wire logic [1:0] sel,
    // Ticks
    input wire logic tick_in,
    output logic tick_out
);

    // ------------------------------------------------------------
    // Body
    // ------------------------------------------------------------
    // Refused at elaboration: the mask logic only serves ratios up to 1:8
    if (CNT_W != 3) begin : g_bad_cnt_w
        $error("ttc_prescale: CNT_W must be 3 for 1:8");
    end

    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] mask;

    // Mask of low bits that must all be set before a tick passes
    always_comb begin
        mask = CNT_W'((4'h1 << sel) - 4'h1);
    end

    assign tick_out = tick_in && ((cnt_reg & mask) == mask);

    // Free counter of input ticks; clear wins so a write restarts cleanly
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= '0;
        end else if (clr) begin
            cnt_reg <= '0;
        end else if (tick_in) begin
            cnt_reg <= cnt_reg + CNT_W'(1);
        end
    end

endmodule : ttc_prescale

`default_nettype wire

// [hw/ttc_edge.sv]
`timescale 1ns/1ps
`default_nettype none

// Rising edge finder with an optional two-stage synchroniser in front
module ttc_edge (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Source and mode
    input wire logic pin,
    input wire logic bypass_sync,
    // Result
    output logic rise
);

    // ------------------------------------------------------------
    // Body
    // ------------------------------------------------------------
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;
    logic raw_d_reg;

    // Synchronised path; the first stage feeds only the second
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
            raw_d_reg <= 1'b0;
        end else begin
            s1_reg <= pin;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            raw_d_reg <= pin;
        end
    end

    // Bypass trades metastability margin for two cycles less latency
    assign rise = bypass_sync ? (pin && !raw_d_reg) : (s2_reg && !s3_reg);

endmodule : ttc_edge

`default_nettype wire

// [hw/ttc_timer.sv]
`timescale 1ns/1ps
`default_nettype none

module ttc_timer #(
    parameter int COUNT_W = 16
) (
    // Clock and reset
    input wire logic MCLK,
    input wire logic RST_N,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Count sources
    input wire logic EXT_COUNT_CLOCK_PIN,
    input wire logic OSC_CLOCK,
    input wire logic COMPARE_UNIT_TRIGGER,
    input wire logic SYSCLK_FROM_OSC,
    // Oscillator pin control
    input wire logic OSC_IN_PIN,
    input wire logic OSC_OUT_PIN,
    input wire logic [1:0] OSC_PIN_DIRECTION_BITS,
    output logic OSC_ENABLE,
    output logic [1:0] OSC_PIN_INPUT_MODE,
    output logic [1:0] OSC_PIN_PORT_READ,
    // Overflow event
    output logic OVERFLOW_IRQ
);

    // ------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------
    // Refused at elaboration: the byte map assumes exactly two bytes
    if (COUNT_W != 16) begin : g_bad_count_w
        $error("ttc_timer: COUNT_W must be 16, two byte registers");
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    ttc_pkg::ttc_ctrl_s ctrl_reg;
    logic [COUNT_W-1:0] count_reg;
    logic [7:0] high_buf_reg;
    logic overflow_flag_reg;
    logic overflow_irq_enable_reg;
    logic [31:0] prdata_reg;
    logic pslverr_reg;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    logic setup_ph;
    logic access_ph;
    logic wr_ctrl;
    logic wr_low;
    logic wr_high;
    logic wr_irq;
    logic rd_low;
    logic mapped;

    assign setup_ph = PSEL && !PENABLE;
    assign access_ph = PSEL && PENABLE;

    // Zero wait states: data was captured in the setup cycle
    assign PREADY = 1'b1;
    assign PRDATA = prdata_reg;
    assign PSLVERR = pslverr_reg;

    assign mapped = (PADDR == ttc_pkg::CTRL_OFS) || (PADDR == ttc_pkg::LOW_OFS)
        || (PADDR == ttc_pkg::HIGH_OFS) || (PADDR == ttc_pkg::IRQ_OFS);
    assign wr_ctrl = access_ph && PWRITE && (PADDR == ttc_pkg::CTRL_OFS);
    assign wr_low = access_ph && PWRITE && (PADDR == ttc_pkg::LOW_OFS);
    assign wr_high = access_ph && PWRITE && (PADDR == ttc_pkg::HIGH_OFS);
    assign wr_irq = access_ph && PWRITE && (PADDR == ttc_pkg::IRQ_OFS);
    // Same edge as the low byte capture, so a carry cannot tear the pair
    assign rd_low = setup_ph && !PWRITE && (PADDR == ttc_pkg::LOW_OFS);

    // ------------------------------------------------------------
    // Mode and count clock
    // ------------------------------------------------------------
    ttc_pkg::ttc_mode_e mode;
    logic ext_source;
    logic ext_rise;
    logic instr_tick;
    logic src_tick;
    logic count_tick;
    logic presc_clr;

    // Mode from source select and sync bit; sync bit ignored when internal
    always_comb begin
        if (!ctrl_reg.clock_source_select) begin
            mode = ttc_pkg::MODE_TIMER;
        end else if (ctrl_reg.ext_sync_disable) begin
            mode = ttc_pkg::MODE_ASYNC_CNT;
        end else begin
            mode = ttc_pkg::MODE_SYNC_CNT;
        end
    end

    // Oscillator output replaces the pin when the oscillator is on
    assign ext_source = ctrl_reg.osc_enable ? OSC_CLOCK : EXT_COUNT_CLOCK_PIN;

    ttc_edge u_edge (
        .clk(MCLK),
        .rst_n(RST_N),
        .pin(ext_source),
        .bypass_sync(mode == ttc_pkg::MODE_ASYNC_CNT),
        .rise(ext_rise)
    );

    // Instruction cycle tick: a fixed 1:4 instance of the prescaler
    ttc_prescale u_instr_div (
        .clk(MCLK),
        .rst_n(RST_N),
        .clr(1'b0),
        .sel(ttc_pkg::INSTR_DIV_SEL),
        .tick_in(1'b1),
        .tick_out(instr_tick)
    );

    always_comb begin
        case (mode)
            ttc_pkg::MODE_TIMER: src_tick = instr_tick;
            ttc_pkg::MODE_SYNC_CNT: src_tick = ext_rise;
            ttc_pkg::MODE_ASYNC_CNT: src_tick = ext_rise;
            default: src_tick = 1'b0;
        endcase
    end

    // Only low-byte writes restart the prescaler, in either access mode
    assign presc_clr = wr_low;

    ttc_prescale u_presc (
        .clk(MCLK),
        .rst_n(RST_N),
        .clr(presc_clr),
        .sel(ctrl_reg.prescale_select),
        .tick_in(src_tick && ctrl_reg.count_run),
        .tick_out(count_tick)
    );

    // ------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------
    // Status bit is never stored; it is read live from the clock switch
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            ctrl_reg <= ttc_pkg::CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl_reg <= PWDATA[7:0];
            ctrl_reg.sysclk_from_osc_status <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Counter and high-byte buffer
    // ------------------------------------------------------------
    logic any_count_write;
    logic overflow_evt;

    assign any_count_write = wr_low || (wr_high && !ctrl_reg.wide_access_mode);

    // Writes beat the compare reset, which beats counting
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            count_reg <= ttc_pkg::COUNT_ZERO;
        end else if (wr_low && ctrl_reg.wide_access_mode) begin
            count_reg <= {high_buf_reg, PWDATA[7:0]};
        end else if (wr_low) begin
            count_reg <= {count_reg[15:8], PWDATA[7:0]};
        end else if (wr_high && !ctrl_reg.wide_access_mode) begin
            count_reg <= {PWDATA[7:0], count_reg[7:0]};
        end else if (COMPARE_UNIT_TRIGGER) begin
            count_reg <= ttc_pkg::COUNT_ZERO;
        end else if (count_tick) begin
            count_reg <= count_reg + 16'h0001;
        end
    end

    // In wide mode the buffer snapshots the live high byte on low reads and takes high writes
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            high_buf_reg <= ttc_pkg::BYTE_ZERO;
        end else if (wr_high && ctrl_reg.wide_access_mode) begin
            high_buf_reg <= PWDATA[7:0];
        end else if (rd_low && ctrl_reg.wide_access_mode) begin
            high_buf_reg <= count_reg[15:8];
        end
    end

    // ------------------------------------------------------------
    // Overflow flag
    // ------------------------------------------------------------
    // A write or compare reset in the same cycle preempts the wrap
    assign overflow_evt = count_tick && (count_reg == ttc_pkg::COUNT_MAX)
        && !any_count_write && !COMPARE_UNIT_TRIGGER;

    // Set wins over the write-one-to-clear
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            overflow_flag_reg <= 1'b0;
        end else if (overflow_evt) begin
            overflow_flag_reg <= 1'b1;
        end else if (wr_irq && PWDATA[ttc_pkg::IRQ_FLAG_BIT]) begin
            overflow_flag_reg <= 1'b0;
        end
    end

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            overflow_irq_enable_reg <= 1'b0;
        end else if (wr_irq) begin
            overflow_irq_enable_reg <= PWDATA[ttc_pkg::IRQ_EN_BIT];
        end
    end

    assign OVERFLOW_IRQ = overflow_flag_reg && overflow_irq_enable_reg;

    // ------------------------------------------------------------
    // Oscillator and pin control
    // ------------------------------------------------------------
    // Enable follows the bit only; no power mode input can stop it
    assign OSC_ENABLE = ctrl_reg.osc_enable;

    // Pins become inputs and read as zero while the oscillator owns them
    assign OSC_PIN_INPUT_MODE = ctrl_reg.osc_enable ? 2'h3 : OSC_PIN_DIRECTION_BITS;
    assign OSC_PIN_PORT_READ = ctrl_reg.osc_enable ? 2'h0 : {OSC_IN_PIN, OSC_OUT_PIN};

    // ------------------------------------------------------------
    // Read data, captured in the setup cycle
    // ------------------------------------------------------------
    logic [31:0] rd_word;
    ttc_pkg::ttc_ctrl_s ctrl_view;

    always_comb begin
        ctrl_view = ctrl_reg;
        ctrl_view.sysclk_from_osc_status = SYSCLK_FROM_OSC;
        rd_word = ttc_pkg::WORD_ZERO;
        case (PADDR)
            ttc_pkg::CTRL_OFS: rd_word[7:0] = ctrl_view;
            ttc_pkg::LOW_OFS: rd_word[7:0] = count_reg[7:0];
            ttc_pkg::HIGH_OFS: begin
                // Wide mode reads the snapshot, byte mode the live byte
                rd_word[7:0] = ctrl_reg.wide_access_mode ? high_buf_reg
                    : count_reg[15:8];
            end
            ttc_pkg::IRQ_OFS: begin
                rd_word[ttc_pkg::IRQ_FLAG_BIT] = overflow_flag_reg;
                rd_word[ttc_pkg::IRQ_EN_BIT] = overflow_irq_enable_reg;
            end
            default: rd_word = ttc_pkg::WORD_ZERO;
        endcase
    end

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            prdata_reg <= ttc_pkg::WORD_ZERO;
            pslverr_reg <= 1'b0;
        end else if (setup_ph) begin
            prdata_reg <= PWRITE ? ttc_pkg::WORD_ZERO : rd_word;
            pslverr_reg <= !mapped;
        end
    end

endmodule : ttc_timer

`default_nettype wire

// [bench/ttc_timer_monitor.sv]
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Port-level checker for the timer block
// ----------------------------------------
module ttc_mon (
    // Clock and reset
    input wire logic MCLK,
    input wire logic RST_N,
    // APB
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    // Sources and pins
    input wire logic COMPARE_UNIT_TRIGGER,
    input wire logic SYSCLK_FROM_OSC,
    input wire logic OSC_IN_PIN,
    input wire logic OSC_OUT_PIN,
    input wire logic [1:0] OSC_PIN_DIRECTION_BITS,
    input wire logic OSC_ENABLE,
    input wire logic [1:0] OSC_PIN_INPUT_MODE,
    input wire logic [1:0] OSC_PIN_PORT_READ,
    input wire logic OVERFLOW_IRQ
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_N);
    // Decoded bus phases
    logic wr_cyc;
    logic rd_setup;
    assign wr_cyc = PSEL && PENABLE && PWRITE;
    assign rd_setup = PSEL && !PENABLE && !PWRITE;
    // Trigger held with no write in the way, then a low-byte read
    sequence s_cmp_hold;
        COMPARE_UNIT_TRIGGER && !wr_cyc;
    endsequence
    sequence s_low_rd;
        rd_setup && PADDR == ttc_pkg::LOW_OFS;
    endsequence
    property p_osc_force;
        OSC_ENABLE |-> OSC_PIN_INPUT_MODE == 2'h3 && OSC_PIN_PORT_READ == 2'h0;
    endproperty
    property p_osc_pass;
        !OSC_ENABLE |-> OSC_PIN_INPUT_MODE == OSC_PIN_DIRECTION_BITS;
    endproperty
    property p_osc_read;
        !OSC_ENABLE |-> OSC_PIN_PORT_READ == {OSC_IN_PIN, OSC_OUT_PIN};
    endproperty
    property p_osc_wr;
        wr_cyc && PADDR == ttc_pkg::CTRL_OFS |=> OSC_ENABLE == $past(PWDATA[3]);
    endproperty
    property p_run_status;
        rd_setup && PADDR == ttc_pkg::CTRL_OFS |=> PRDATA[6] == $past(SYSCLK_FROM_OSC);
    endproperty
    property p_rst;
        $rose(RST_N) |-> !OSC_ENABLE && !OVERFLOW_IRQ && PRDATA == 32'h0;
    endproperty
    property p_cmp_clear;
        s_cmp_hold ##1 s_low_rd |=> PRDATA[7:0] == 8'h00;
    endproperty
    property p_irq_off;
        wr_cyc && PADDR == ttc_pkg::IRQ_OFS && !PWDATA[1] |=> !OVERFLOW_IRQ [*2];
    endproperty
    a_osc_force: assert property (p_osc_force) else $error("osc pins not forced");
    a_osc_pass: assert property (p_osc_pass) else $error("pin direction wrong");
    a_osc_read: assert property (p_osc_read) else $error("pin read wrong");
    a_osc_wr: assert property (p_osc_wr) else $error("osc enable not set");
    a_run_status: assert property (p_run_status) else $error("bit 6 wrong");
    a_rst: assert property (p_rst) else $error("reset state wrong");
    a_cmp_clear: assert property (p_cmp_clear) else $error("trigger no clear");
    a_irq_off: assert property (p_irq_off) else $error("masked irq seen");
endmodule : ttc_mon

bind ttc_timer ttc_mon u_mon (.MCLK(MCLK), .RST_N(RST_N), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .COMPARE_UNIT_TRIGGER(COMPARE_UNIT_TRIGGER),
    .SYSCLK_FROM_OSC(SYSCLK_FROM_OSC), .OSC_IN_PIN(OSC_IN_PIN),
    .OSC_OUT_PIN(OSC_OUT_PIN), .OSC_PIN_DIRECTION_BITS(OSC_PIN_DIRECTION_BITS),
    .OSC_ENABLE(OSC_ENABLE), .OSC_PIN_INPUT_MODE(OSC_PIN_INPUT_MODE),
    .OSC_PIN_PORT_READ(OSC_PIN_PORT_READ), .OVERFLOW_IRQ(OVERFLOW_IRQ));
`default_nettype wire

// [bench/ttc_src.sv]
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// External clock source and crystal model
// ----------------------------------------
module ttc_src #(
    parameter int HALF = 3
) (
    // Clock
    input wire logic mclk,
    // Control
    input wire logic run,
    input wire logic osc_on,
    // Source outputs
    output logic ext_pin,
    output logic osc_pin,
    output logic [15:0] rises
);
    logic lvl;
    logic [3:0] ph;
    initial begin
        lvl = 1'b0;
        ph = 4'h0;
        rises = 16'h0000;
    end
    // Square wave only inside bursts; stands low between them
    always @(posedge mclk) begin
        if (!run) begin
            lvl <= 1'b0;
            ph <= 4'h0;
        end else if (ph == 4'(HALF - 1)) begin
            ph <= 4'h0;
            lvl <= !lvl;
            rises <= rises + 16'(!lvl);
        end else begin
            ph <= ph + 4'h1;
        end
    end
    // Crystal drives only when enabled; a shut-off cell does not swing
    assign osc_pin = osc_on ? lvl : 1'b0;
    assign ext_pin = osc_on ? 1'b0 : lvl;
endmodule : ttc_src
`default_nettype wire

// [bench/ttc_timer_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Self-checking bench for the timer block
// ----------------------------------------
module ttc_timer_tb_top;
    logic mclk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rq;
    logic pready, pslverr, re, osc_en, irq, ext_pin, osc_pin, src_run = 0;
    logic trig = 0, sysosc = 0, osc_in = 0, osc_out = 1;
    logic [1:0] dir = 2'h1, pin_mode, pin_read;
    logic [15:0] rises, r0;
    logic [7:0] mode [3] = '{8'h03, 8'h07, 8'h0b};
    int failures = 0, n_compared = 0, cyc = 0;
    logic [7:0] e;

    always #25 mclk = ~mclk;

    ttc_timer uut (.MCLK(mclk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .EXT_COUNT_CLOCK_PIN(ext_pin),
        .OSC_CLOCK(osc_pin), .COMPARE_UNIT_TRIGGER(trig), .SYSCLK_FROM_OSC(sysosc),
        .OSC_IN_PIN(osc_in), .OSC_OUT_PIN(osc_out), .OSC_PIN_DIRECTION_BITS(dir),
        .OSC_ENABLE(osc_en), .OSC_PIN_INPUT_MODE(pin_mode),
        .OSC_PIN_PORT_READ(pin_read), .OVERFLOW_IRQ(irq));
    ttc_src src (.mclk(mclk), .run(src_run), .osc_on(osc_en), .ext_pin(ext_pin),
        .osc_pin(osc_pin), .rises(rises));

    // ----------------------------------------
    // Bus tasks and comparison
    // ----------------------------------------
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        rq = prdata;
        re = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(a, 1'b1, d);
    endtask : wr
    task automatic rd(input logic [7:0] a);
        apb(a, 1'b0, 32'h0);
    endtask : rd
    task automatic check(input string n, input logic [31:0] s, input logic [31:0] x);
        n_compared++;
        if (s !== x) begin
            failures++;
            $display("BAD %s expected %h seen %h", n, x, s);
        end
    endtask : check
    task automatic wrap_up;
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : wrap_up

    // Hang guard, far above the few thousand cycles the tests need
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 12000) begin
            failures++;
            wrap_up();
        end
    end

    initial begin
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        for (int i = 0; i < 16; i += 4) begin
            rd(8'(i));
            check("reset", rq, 32'h0);
        end
        rd(8'h10);
        check("unmapped", {re, rq[30:0]}, 32'h8000_0000);
        // Prescale ratios; bit 2 set on the 1:2 and 1:8 ratios must not matter
        for (int p = 0; p < 4; p++) begin
            wr(ttc_pkg::LOW_OFS, 32'h0);
            wr(ttc_pkg::HIGH_OFS, 32'h0);
            wr(ttc_pkg::CTRL_OFS, {26'h0, 2'(p), 1'b0, 1'(p), 2'h1});
            repeat (317) @(posedge mclk);
            wr(ttc_pkg::CTRL_OFS, 32'h0);
            rd(ttc_pkg::LOW_OFS);
            e = 8'(80 >> p);
            check("rate", rq[7:0] >= e - 1 && rq[7:0] <= e + 1, 1);
        end
        repeat (40) @(posedge mclk);
        e = rq[7:0];
        rd(ttc_pkg::LOW_OFS);
        check("stopped", rq[7:0], e);
        // Counter modes from the pin and from the crystal
        for (int m = 0; m < 3; m++) begin
            dir <= 2'(m);
            wr(ttc_pkg::HIGH_OFS, 32'h0);
            wr(ttc_pkg::LOW_OFS, 32'h0);
            wr(ttc_pkg::CTRL_OFS, mode[m]);
            if (m == 2) repeat (100) @(posedge mclk);
            if (m == 2) check("pinmode", pin_mode, 2'h3);
            if (m == 2) check("pinread", pin_read, 2'h0);
            if (m != 2) check("pindir", pin_mode, dir);
            r0 = rises;
            src_run <= 1'b1;
            osc_in <= 1'b1;
            repeat (200) @(posedge mclk);
            src_run <= 1'b0;
            repeat (10) @(posedge mclk);
            wr(ttc_pkg::CTRL_OFS, 32'h0);
            rd(ttc_pkg::LOW_OFS);
            check("edges", rq[7:0], 8'(rises - r0));
        end
        // Byte and wide access
        wr(ttc_pkg::HIGH_OFS, 32'hab);
        wr(ttc_pkg::LOW_OFS, 32'hcd);
        wr(ttc_pkg::CTRL_OFS, 32'h80);
        wr(ttc_pkg::HIGH_OFS, 32'h12);
        wr(ttc_pkg::CTRL_OFS, 32'h0);
        rd(ttc_pkg::HIGH_OFS);
        check("live_high", rq, 32'hab);
        wr(ttc_pkg::CTRL_OFS, 32'h80);
        wr(ttc_pkg::LOW_OFS, 32'h34);
        wr(ttc_pkg::CTRL_OFS, 32'h0);
        rd(ttc_pkg::HIGH_OFS);
        check("loaded_high", rq, 32'h12);
        wr(ttc_pkg::HIGH_OFS, 32'h56);
        wr(ttc_pkg::CTRL_OFS, 32'h80);
        rd(ttc_pkg::LOW_OFS);
        check("wide_low", rq, 32'h34);
        wr(ttc_pkg::CTRL_OFS, 32'h0);
        wr(ttc_pkg::HIGH_OFS, 32'h77);
        wr(ttc_pkg::CTRL_OFS, 32'h80);
        rd(ttc_pkg::HIGH_OFS);
        check("buffer", rq, 32'h56);
        // Overflow, flag and mask
        wr(ttc_pkg::CTRL_OFS, 32'h0);
        wr(ttc_pkg::HIGH_OFS, 32'hff);
        wr(ttc_pkg::LOW_OFS, 32'hfc);
        wr(ttc_pkg::IRQ_OFS, 32'h3);
        wr(ttc_pkg::CTRL_OFS, 32'h1);
        repeat (40) @(posedge mclk);
        wr(ttc_pkg::CTRL_OFS, 32'h0);
        rd(ttc_pkg::IRQ_OFS);
        check("flag", {rq[30:0], irq}, 32'h7);
        rd(ttc_pkg::HIGH_OFS);
        check("wrap", rq, 32'h0);
        wr(ttc_pkg::IRQ_OFS, 32'h1);
        rd(ttc_pkg::IRQ_OFS);
        check("cleared", {rq[30:0], irq}, 32'h0);
        // Compare reset and clock status
        // Trigger raised only at the edge that takes the low write
        fork
            wr(ttc_pkg::LOW_OFS, 32'h50);
            begin
                repeat (2) @(posedge mclk);
                trig <= 1'b1;
                @(posedge mclk);
                trig <= 1'b0;
            end
        join
        rd(ttc_pkg::LOW_OFS);
        check("cmp_wr", rq, 32'h50);
        trig <= 1'b1;
        repeat (2) @(posedge mclk);
        rd(ttc_pkg::LOW_OFS);
        check("cmp", rq, 32'h0);
        trig <= 1'b0;
        sysosc <= 1'b1;
        wr(ttc_pkg::CTRL_OFS, 32'h08);
        rd(ttc_pkg::CTRL_OFS);
        check("status", rq, 32'h48);
        sysosc <= 1'b0;
        wr(ttc_pkg::CTRL_OFS, 32'h40);
        rd(ttc_pkg::CTRL_OFS);
        check("status_ro", rq, 32'h0);
        wrap_up();
    end
endmodule : ttc_timer_tb_top
`default_nettype wire
